// file: core/hsb_pkg.sv
// constants for the schedule half select register bank
// assumes one clock domain and a plain address/strobe register port
// Summary of operation
// - bit 19 reads which half the async list is being processed from
// - lower async half: processing starts at the lower async start pointer
// - upper async half: processing starts at the upper async start pointer
// - bit 18 reads which half the periodic list is being processed from
// - periodic processing starts at the base entry of the named half
// - bit 17 periodic change request, switch at frame edge, hardware clears
// - bit 16 async change request, switch at microframe edge, hardware clears
// - lower half holds entries 0 to 95, upper half 96 to 191
// - bits 15:8 writable upper half first async entry pointer
// - bits 7:0 writable lower half first async entry pointer
package hsb_pkg;
    localparam logic [31:0] HSB_CTRL_ADDR   = 32'he0032010;
    localparam int          HSB_ASYNC_IND_BIT = 19;
    localparam int          HSB_PERI_IND_BIT  = 18;
    localparam int          HSB_PERI_REQ_BIT  = 17;
    localparam int          HSB_ASYNC_REQ_BIT = 16;
    localparam int          HSB_UPTR_LSB      = 8;
    localparam int          HSB_LPTR_LSB      = 0;
    localparam logic [7:0]  HSB_PTR_RESET     = 8'h00;
    localparam logic [7:0]  HSB_LOWER_BASE    = 8'h00;
    localparam logic [7:0]  HSB_LOWER_LAST    = 8'h5f;
    localparam logic [7:0]  HSB_UPPER_BASE    = 8'h60;
    localparam logic [7:0]  HSB_UPPER_LAST    = 8'hbf;
endpackage

// file: core/hsb_schedule_half_control.sv
// schedule half select register and switching logic for a host scheduler
// assumes frame and microframe boundary pulses come from scheduler logic on mclk
module hsb_schedule_half_control
(
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_b,
    // register port
    input  wire logic [31:0] reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // scheduler timing, one-cycle pulses
    input  wire logic        frame_boundary,
    input  wire logic        uframe_boundary,
    // scheduler side outputs
    output logic             async_half_indicator,
    output logic             periodic_half_indicator,
    output logic      [7:0]  async_start_entry,
    output logic      [7:0]  periodic_base_entry,
    output logic      [7:0]  async_half_first,
    output logic      [7:0]  async_half_last,
    output logic             periodic_switch,
    output logic             async_switch
);
    import hsb_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    logic       rst_meta_b;
    logic       rst_sync_b;
    logic       periodic_change_request;
    logic       async_change_request;
    logic [7:0] upper_async_start_pointer;
    logic [7:0] lower_async_start_pointer;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_b <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rst_meta_b <= 1'b1;
            rst_sync_b <= rst_meta_b;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    wire hit        = (reg_addr == HSB_CTRL_ADDR);
    wire wr_hit     = reg_wr && hit;
    wire set_peri   = wr_hit && reg_wdata[HSB_PERI_REQ_BIT];
    wire set_async  = wr_hit && reg_wdata[HSB_ASYNC_REQ_BIT];

    // a periodic flip also moves the async list, since both lists share the halves
    assign periodic_switch = frame_boundary && periodic_change_request;
    assign async_switch    = periodic_switch ||
                             (uframe_boundary && async_change_request);

    // set wins over the hardware clear so a request written at the boundary waits
    wire next_peri_req  = set_peri  || (periodic_change_request && !periodic_switch);
    wire next_async_req = set_async || (async_change_request && !async_switch);

    always_ff @(posedge mclk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            periodic_change_request   <= 1'b0;
            async_change_request      <= 1'b0;
            periodic_half_indicator   <= 1'b0;
            async_half_indicator      <= 1'b0;
            upper_async_start_pointer <= HSB_PTR_RESET;
            lower_async_start_pointer <= HSB_PTR_RESET;
        end else begin
            periodic_change_request <= next_peri_req;
            async_change_request    <= next_async_req;
            if (periodic_switch) begin
                periodic_half_indicator <= !periodic_half_indicator;
            end
            if (async_switch) begin
                async_half_indicator <= !async_half_indicator;
            end
            if (wr_hit) begin
                upper_async_start_pointer <= reg_wdata[HSB_UPTR_LSB +: 8];
                lower_async_start_pointer <= reg_wdata[HSB_LPTR_LSB +: 8];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign async_start_entry   = async_half_indicator ? upper_async_start_pointer
                                                      : lower_async_start_pointer;
    assign periodic_base_entry = periodic_half_indicator ? HSB_UPPER_BASE : HSB_LOWER_BASE;
    assign async_half_first    = async_half_indicator ? HSB_UPPER_BASE : HSB_LOWER_BASE;
    assign async_half_last     = async_half_indicator ? HSB_UPPER_LAST : HSB_LOWER_LAST;

    wire [31:0] read_word = {12'h000,
                             async_half_indicator,
                             periodic_half_indicator,
                             periodic_change_request,
                             async_change_request,
                             upper_async_start_pointer,
                             lower_async_start_pointer};

    // unmapped reads return zero; data stands only in the cycle after the strobe
    always_ff @(posedge mclk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            reg_rdata <= 32'h00000000;
        end else begin
            reg_rdata <= (reg_rd && hit) ? read_word : 32'h00000000;
        end
    end
endmodule

// file: verification/hsb_chk_assertions.sv
// checker for the schedule half select register bank
// bound to the top module, sees its ports only, one clock domain
module hsb_chk
    import hsb_pkg::*;
(
    input wire logic        mclk, rst_b, reg_wr, reg_rd, frame_boundary, uframe_boundary,
    input wire logic [31:0] reg_addr, reg_wdata, reg_rdata,
    input wire logic        async_half_indicator, periodic_half_indicator, periodic_switch, async_switch,
    input wire logic [7:0]  async_start_entry, periodic_base_entry, async_half_first, async_half_last
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    sequence rd_taken;
        reg_rd && reg_addr == HSB_CTRL_ADDR;
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    chk_rd_async: assert property (rd_taken |=> reg_rdata[19] == $past(async_half_indicator))
        else $error("async half bit wrong");
    chk_rd_peri: assert property (rd_taken |=> reg_rdata[18] == $past(periodic_half_indicator))
        else $error("periodic half bit wrong");
    chk_peri_base: assert property (periodic_base_entry == (periodic_half_indicator ? 8'h60 : 8'h00))
        else $error("periodic base wrong");
    chk_half_range: assert property (async_half_first == (async_half_indicator ? 8'h60 : 8'h00)
        && async_half_last == (async_half_indicator ? 8'hbf : 8'h5f)) else $error("half range wrong");
    chk_peri_flip: assert property (periodic_switch |=> periodic_half_indicator != $past(periodic_half_indicator))
        else $error("periodic half kept");
    chk_async_flip: assert property (async_switch |=> async_half_indicator != $past(async_half_indicator))
        else $error("async half kept");
    chk_peri_hold: assert property (!periodic_switch |=> $stable(periodic_half_indicator))
        else $error("periodic half moved");
    chk_async_hold: assert property (!async_switch |=> $stable(async_half_indicator))
        else $error("async half moved");
    chk_switch_cause: assert property (async_switch |-> frame_boundary || uframe_boundary)
        else $error("switch off boundary");
endmodule
bind hsb_schedule_half_control hsb_chk chk (.*);

// file: verification/testbench.sv
// self-checking bench for the schedule half select register bank
// drives every top module port directly, no partner model
`define CK(a, b) begin tests_run++; if ((a) !== (b)) begin errors++; $display("unexpected %0t %h", $time, a); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import hsb_pkg::*;
    logic        mclk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, frame_boundary = 0, uframe_boundary = 0;
    logic [31:0] reg_addr = 0, reg_wdata = 0, reg_rdata, q;
    logic        async_half_indicator, periodic_half_indicator, periodic_switch, async_switch;
    logic [7:0]  async_start_entry, periodic_base_entry, async_half_first, async_half_last;
    int          errors = 0, tests_run = 0;
    // rows: written word, word read back; zeros in 17:16 and writes above 19 change nothing
    logic [31:0] rows [2][2] = '{'{32'h000fa55a, 32'h0003a55a}, '{32'hfff01234, 32'h00031234}};
    always #20 mclk = ~mclk;
    hsb_schedule_half_control uut (.*);
    ////////////////////////////////////////////////////////////////////////////////
    task wr(input logic [31:0] d);
        @(posedge mclk); reg_addr <= HSB_CTRL_ADDR; reg_wdata <= d; reg_wr <= 1'b1;
        @(posedge mclk); reg_wr <= 1'b0;
    endtask
    task rd(input logic [31:0] a);
        @(posedge mclk); reg_addr <= a; reg_rd <= 1'b1;
        @(posedge mclk); reg_rd <= 1'b0;
        #1 q = reg_rdata;
    endtask
    task pulse(input logic f, input logic u);
        @(posedge mclk); frame_boundary <= f; uframe_boundary <= u;
        @(posedge mclk); frame_boundary <= 1'b0; uframe_boundary <= 1'b0;
        #1;
    endtask
    task final_report;
        if (errors == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (3) @(posedge mclk);
        rd(HSB_CTRL_ADDR); `CK(q, 32'h0)
        foreach (rows[i]) begin
            wr(rows[i][0]); rd(HSB_CTRL_ADDR); `CK(q, rows[i][1])
        end
        rd(32'he0032014); `CK(q, 32'h0)
        pulse(1'b1, 1'b0); `CK(periodic_base_entry, 8'h60)
        `CK(async_start_entry, 8'h12)
        rd(HSB_CTRL_ADDR); `CK(q, 32'h000c1234)
        // boundaries with no request pending must leave everything alone
        pulse(1'b1, 1'b1); rd(HSB_CTRL_ADDR); `CK(q, 32'h000c1234)
        wr(32'h00015678); pulse(1'b0, 1'b1); `CK(async_start_entry, 8'h78)
        rd(HSB_CTRL_ADDR); `CK(q, 32'h00045678)
        // request rewritten in the very cycle of its switch must stay set
        wr(32'h00025678);
        @(posedge mclk); reg_wr <= 1'b1; frame_boundary <= 1'b1;
        @(posedge mclk); reg_wr <= 1'b0; frame_boundary <= 1'b0;
        #1 `CK(async_start_entry, 8'h56)
        rd(HSB_CTRL_ADDR); `CK(q, 32'h000a5678)
        rst_b <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (3) @(posedge mclk);
        rd(HSB_CTRL_ADDR); `CK(q, 32'h0)
        final_report;
    end
    initial begin
        #200000 errors++;
        final_report;
    end
endmodule
